// *** rtl/asc_pkg.sv ***
// shared constants and types for the adc serial command block
// assumes a mode 1 serial host and a 50 MHz core clock beside it
package asc_pkg;

  // ---------------------------------------------------------------
  // register offsets (two-bit address carried in command bytes)
  // ---------------------------------------------------------------
  localparam logic [1:0] ASC_OFF_INPUT_AND_GAIN = 2'h0;
  localparam logic [1:0] ASC_OFF_RATE_AND_CONV = 2'h1;
  localparam logic [1:0] ASC_OFF_REF_AND_SOURCE = 2'h2;
  localparam logic [1:0] ASC_OFF_ROUTING_AND_READY = 2'h3;
  localparam int ASC_NUM_REGS = 4;
  localparam logic [7:0] ASC_CFG_RESET = 8'h00;
  // reserved bit 0 of the routing register never stores a one
  localparam logic [7:0] ASC_ROUTING_WRITE_MASK = 8'hfe;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int ASC_SEL_LSB = 4;
  localparam int ASC_GAIN_LSB = 1;
  localparam int ASC_BYPASS_BIT = 0;
  localparam int ASC_TEMP_BIT = 1;
  localparam int ASC_READY_ON_DOUT_BIT = 1;

  // ---------------------------------------------------------------
  // command opcodes (upper nibble of a command byte)
  // ---------------------------------------------------------------
  localparam logic [3:0] ASC_OP_READ_RESULT = 4'h1;
  localparam logic [3:0] ASC_OP_REG_READ = 4'h2;
  localparam logic [3:0] ASC_OP_REG_WRITE = 4'h4;

  // ---------------------------------------------------------------
  // input select and gain encodings
  // ---------------------------------------------------------------
  localparam logic [3:0] ASC_SEL_QUARTER_MON = 4'hd;
  localparam logic [3:0] ASC_SEL_MID_SHORT = 4'he;
  localparam logic [3:0] ASC_SEL_UNUSED = 4'hf;
  localparam logic [1:0] ASC_SEL_TO_GND_HI = 2'h2;
  localparam logic [2:0] ASC_GAIN_MAX_BYPASS = 3'h2;
  localparam logic [2:0] ASC_GAIN_UNITY = 3'h0;
  localparam logic [7:0] ASC_GAIN_ONE = 8'h01;

  // ---------------------------------------------------------------
  // serial framing counts
  // ---------------------------------------------------------------
  localparam logic [2:0] ASC_LAST_BIT = 3'h7;
  localparam logic [2:0] ASC_FIRST_BIT = 3'h0;
  localparam logic [1:0] ASC_RESULT_BYTES_M1 = 2'h1;
  localparam int ASC_RESULT_BITS = 16;

  typedef enum logic [1:0] {
    ASC_IDLE,
    ASC_WR_DATA,
    ASC_RD_REG,
    ASC_RD_RESULT
  } asc_state_e;

  // raw configuration bytes as software wrote them
  typedef struct packed {
    logic [7:0] routing_and_ready;
    logic [7:0] ref_and_source;
    logic [7:0] rate_and_conv;
    logic [7:0] input_and_gain;
  } asc_cfg_s;

  // effective front-end controls after the field interlocks
  typedef struct packed {
    logic [3:0] input_select;
    logic [7:0] gain_mult;
    logic amp_en;
    logic temp_mode;
    logic quarter_monitor;
    logic mid_short;
    logic sel_invalid;
  } asc_analog_s;

endpackage : asc_pkg

// *** rtl/asc_serial_cmd.sv ***
// serial command decoder and configuration register bank of the adc
// assumes a mode 1 host on sclk/cs_n/din/dout and conversion results
// delivered on clk with a one-cycle conv_done strobe
//
// How it works
// - decode commands while result bytes shift out
// - commands recognised only on byte boundaries
// - read command replaces readout, last byte kept
// - requested data starts next rising edge
// - register write leaves readout shifting untouched
// - completed write restarts the conversion filter
// - no decoding while a read command runs
// - four eight-bit registers, read and write
// - registers change anytime without corrupting data
// - every register resets to zero
// - fixed field layout across four registers
// - temp mode ignores select; ground inputs bypass
// - codes 1101 monitor, 1110 short, 1111 unused
// - gain code is a power of two
// - gain ignored in temperature mode
// - amplifier bypass allowed only for gains 1-4
// - bypass bit zero keeps amplifier on, except for ground inputs and the monitor
// - opcodes: result 0001, read 0010, write 0100
// - writes apply after the last falling edge
// - sample din falling, shift dout rising
`timescale 1ns/100ps
`default_nettype none

module asc_serial_cmd
  import asc_pkg::*;
(
  input wire logic clk, // 50 MHz core clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic sclk, // serial clock from the host
  input wire logic cs_n, // chip select, active low
  input wire logic din, // serial data from the host
  output logic dout, // serial data to the host
  output logic dout_oe_n, // low while dout is driven
  output logic drdy_n, // low while an unread result waits
  input wire logic [15:0] conv_result, // finished conversion word
  input wire logic conv_done, // one-cycle strobe with conv_result
  output asc_cfg_s cfg, // raw configuration bytes
  output asc_analog_s analog, // effective front-end controls
  output logic filter_restart // one-cycle pulse after a write
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  asc_state_e state_q;
  logic [2:0] bit_cnt_q;
  logic [6:0] shreg_q;
  logic [1:0] left_q;
  logic [1:0] addr_q;
  logic commit_q;
  logic [7:0] stage_q [ASC_NUM_REGS];
  logic [ASC_NUM_REGS-1:0] wmask_q;
  logic [7:0] byte_in;
  logic [15:0] out_sh_q;
  logic dout_q;
  logic started_q;
  logic rd_seen_q;
  logic load_en;
  logic load_result;
  logic [15:0] load_word;
  logic cs_meta_q;
  logic cs_idle_q;
  logic cm_meta_q;
  logic cm_sync_q;
  logic cm_last_q;
  logic rd_meta_q;
  logic rd_sync_q;
  logic rd_last_q;
  logic commit_rise;
  logic read_rise;
  logic [7:0] cfg_q [ASC_NUM_REGS];
  logic [15:0] data_buf_q;
  logic [15:0] pend_buf_q;
  logic pend_q;
  logic drdy_n_q;
  logic restart_q;

  // ---------------------------------------------------------------
  // link side, falling edge: sample din and decode bytes
  // ---------------------------------------------------------------
  // the byte just completed on this falling edge
  assign byte_in = {shreg_q, din};

  // cs_n high clears the framing so every frame starts on a byte
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_q <= ASC_FIRST_BIT;
      shreg_q <= 7'h00;
      state_q <= ASC_IDLE;
      left_q <= 2'h0;
      addr_q <= 2'h0;
      commit_q <= 1'b0;
    end else begin
      bit_cnt_q <= bit_cnt_q + 3'd1;
      shreg_q <= byte_in[6:0];
      if (bit_cnt_q == ASC_LAST_BIT) begin
        case (state_q)
          // idle decodes even while a result streams out
          ASC_IDLE: begin
            case (byte_in[7:4])
              ASC_OP_READ_RESULT: begin
                state_q <= ASC_RD_RESULT;
                left_q <= ASC_RESULT_BYTES_M1;
              end
              ASC_OP_REG_READ: begin
                state_q <= ASC_RD_REG;
                addr_q <= byte_in[3:2];
                left_q <= byte_in[1:0];
              end
              ASC_OP_REG_WRITE: begin
                state_q <= ASC_WR_DATA;
                addr_q <= byte_in[3:2];
                left_q <= byte_in[1:0];
                commit_q <= 1'b0;
              end
              default: begin
                state_q <= ASC_IDLE;
              end
            endcase
          end
          // commit level rises only once every data byte is in
          // limitation: cs_n must stay low ~3 clk after, or it is lost
          ASC_WR_DATA: begin
            addr_q <= addr_q + 2'd1;
            left_q <= left_q - 2'd1;
            if (left_q == 2'h0) begin
              state_q <= ASC_IDLE;
              commit_q <= 1'b1;
            end
          end
          // reads swallow din until the last byte leaves
          ASC_RD_REG, ASC_RD_RESULT: begin
            addr_q <= addr_q + 2'd1;
            left_q <= left_q - 2'd1;
            if (left_q == 2'h0) begin
              state_q <= ASC_IDLE;
            end
          end
          default: begin
            state_q <= ASC_IDLE;
          end
        endcase
      end
    end
  end

  // staged write bytes; held steady until the next write command,
  // which gives the core side many sclk periods to copy them
  always_ff @(negedge sclk) begin
    if (!cs_n && bit_cnt_q == ASC_LAST_BIT) begin
      if (state_q == ASC_IDLE && byte_in[7:4] == ASC_OP_REG_WRITE) begin
        wmask_q <= '0;
      end else if (state_q == ASC_WR_DATA) begin
        stage_q[addr_q] <= byte_in;
        wmask_q[addr_q] <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // link side, rising edge: shift data out
  // ---------------------------------------------------------------
  // choose what to load at the start of a byte; register bytes are
  // read straight from the core bank, which only changes on commits
  // that cannot overlap a read
  always_comb begin
    load_en = 1'b0;
    load_result = 1'b0;
    load_word = data_buf_q;
    if (bit_cnt_q == ASC_FIRST_BIT && state_q == ASC_RD_REG) begin
      load_en = 1'b1;
      load_word = {cfg_q[addr_q], 8'h00};
    end else if (bit_cnt_q == ASC_FIRST_BIT &&
                 state_q == ASC_RD_RESULT &&
                 left_q == ASC_RESULT_BYTES_M1) begin
      load_en = 1'b1;
      load_result = 1'b1;
    end else if (!started_q) begin
      load_en = 1'b1;
      load_result = 1'b1;
    end
  end

  // a new load aborts whatever was shifting; a write command never
  // loads, so the result keeps shifting through it
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      out_sh_q <= 16'h0000;
      dout_q <= 1'b0;
      started_q <= 1'b0;
      rd_seen_q <= 1'b0;
    end else begin
      started_q <= 1'b1;
      if (load_en) begin
        dout_q <= load_word[ASC_RESULT_BITS-1];
        out_sh_q <= {load_word[14:0], 1'b0};
        if (load_result) begin
          rd_seen_q <= 1'b1;
        end
      end else begin
        dout_q <= out_sh_q[ASC_RESULT_BITS-1];
        out_sh_q <= {out_sh_q[14:0], 1'b0};
      end
    end
  end

  // before the first rising edge dout may show data-ready instead
  assign dout = started_q ? dout_q :
    (cfg_q[ASC_OFF_ROUTING_AND_READY][ASC_READY_ON_DOUT_BIT] ?
     drdy_n_q : 1'b1);
  assign dout_oe_n = cs_n;

  // ---------------------------------------------------------------
  // crossings into the core clock
  // ---------------------------------------------------------------
  // levels only: the first flop of each pair feeds the second alone
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cs_meta_q <= 1'b1;
      cs_idle_q <= 1'b1;
      cm_meta_q <= 1'b0;
      cm_sync_q <= 1'b0;
      cm_last_q <= 1'b0;
      rd_meta_q <= 1'b0;
      rd_sync_q <= 1'b0;
      rd_last_q <= 1'b0;
    end else begin
      cs_meta_q <= cs_n;
      cs_idle_q <= cs_meta_q;
      cm_meta_q <= commit_q;
      cm_sync_q <= cm_meta_q;
      cm_last_q <= cm_sync_q;
      rd_meta_q <= rd_seen_q;
      rd_sync_q <= rd_meta_q;
      rd_last_q <= rd_sync_q;
    end
  end

  assign commit_rise = cm_sync_q && !cm_last_q;
  assign read_rise = rd_sync_q && !rd_last_q;

  // ---------------------------------------------------------------
  // configuration bank
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < ASC_NUM_REGS; i++) begin
        cfg_q[i] <= ASC_CFG_RESET;
      end
    end else if (commit_rise) begin
      for (int i = 0; i < ASC_NUM_REGS; i++) begin
        if (wmask_q[i]) begin
          cfg_q[i] <= stage_q[i];
        end
      end
      if (wmask_q[ASC_OFF_ROUTING_AND_READY]) begin
        cfg_q[ASC_OFF_ROUTING_AND_READY] <=
          stage_q[ASC_OFF_ROUTING_AND_READY] &
          ASC_ROUTING_WRITE_MASK;
      end
    end
  end

  // restart the filter once the new settings are in place
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= commit_rise && (wmask_q != '0);
    end
  end

  assign filter_restart = restart_q;
  assign cfg = '{routing_and_ready: cfg_q[ASC_OFF_ROUTING_AND_READY],
                 ref_and_source: cfg_q[ASC_OFF_REF_AND_SOURCE],
                 rate_and_conv: cfg_q[ASC_OFF_RATE_AND_CONV],
                 input_and_gain: cfg_q[ASC_OFF_INPUT_AND_GAIN]};

  // ---------------------------------------------------------------
  // result buffer and data-ready
  // ---------------------------------------------------------------
  // the buffer only changes while the host is deselected so the
  // link side never samples a word in the middle of an update
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_buf_q <= 16'h0000;
      pend_buf_q <= 16'h0000;
      pend_q <= 1'b0;
    end else if (conv_done && cs_idle_q) begin
      data_buf_q <= conv_result;
      pend_q <= 1'b0;
    end else if (conv_done) begin
      pend_buf_q <= conv_result;
      pend_q <= 1'b1;
    end else if (pend_q && cs_idle_q) begin
      data_buf_q <= pend_buf_q;
      pend_q <= 1'b0;
    end
  end

  // a read seen in the same cycle wins, since cs_idle_q is low then; the fresh result pends until cs_n is idle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      drdy_n_q <= 1'b1;
    end else if ((conv_done || pend_q) && cs_idle_q) begin
      drdy_n_q <= 1'b0;
    end else if (read_rise) begin
      drdy_n_q <= 1'b1;
    end
  end

  assign drdy_n = drdy_n_q;

  // ---------------------------------------------------------------
  // effective front-end controls
  // ---------------------------------------------------------------
  // temperature mode masks select and gain; ground-referenced
  // inputs and the supply monitor force the bypass path and clamp
  // gain to the range the bypass path supports
  always_comb begin
    logic [3:0] sel;
    logic [2:0] gain;
    logic to_gnd;
    logic temp;
    sel = cfg_q[ASC_OFF_INPUT_AND_GAIN][ASC_SEL_LSB+:4];
    gain = cfg_q[ASC_OFF_INPUT_AND_GAIN][ASC_GAIN_LSB+:3];
    temp = cfg_q[ASC_OFF_RATE_AND_CONV][ASC_TEMP_BIT];
    to_gnd = (sel[3:2] == ASC_SEL_TO_GND_HI) && !temp;
    if (temp) begin
      gain = ASC_GAIN_UNITY;
    end else if ((to_gnd || sel == ASC_SEL_QUARTER_MON) &&
                 gain > ASC_GAIN_MAX_BYPASS) begin
      gain = ASC_GAIN_MAX_BYPASS;
    end
    analog.input_select = temp ? 4'h0 : sel;
    analog.gain_mult = ASC_GAIN_ONE << gain;
    analog.temp_mode = temp;
    analog.quarter_monitor = !temp && sel == ASC_SEL_QUARTER_MON;
    analog.mid_short = !temp && sel == ASC_SEL_MID_SHORT;
    analog.sel_invalid = !temp && sel == ASC_SEL_UNUSED;
    // bypass honoured only at small gains; forced where required
    analog.amp_en = !(analog.quarter_monitor || to_gnd ||
      (cfg_q[ASC_OFF_INPUT_AND_GAIN][ASC_BYPASS_BIT] &&
       gain <= ASC_GAIN_MAX_BYPASS));
  end

endmodule : asc_serial_cmd

`default_nettype wire

// *** tb/asc_serial_cmd_asserts.sv ***
// assertions on the ports of the serial command block
// assumes it is bound into asc_serial_cmd; cfg holds reg3..reg0
`timescale 1ns/100ps
`default_nettype none

module asc_serial_cmd_asserts
  import asc_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic drdy_n, // result waiting, active low
  input wire logic conv_done, // result strobe
  input wire asc_cfg_s cfg, // configuration bytes
  input wire asc_analog_s analog, // front-end controls
  input wire logic filter_restart // restart pulse
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // selections where gain and bypass fields apply unmodified
  logic plain_sel;
  logic gnd_sel;
  assign gnd_sel = cfg.input_and_gain[7:6] == ASC_SEL_TO_GND_HI;
  assign plain_sel = !cfg.rate_and_conv[ASC_TEMP_BIT] && !gnd_sel &&
    cfg.input_and_gain[7:4] != ASC_SEL_QUARTER_MON;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  // reset must be seen, so this one is never disabled
  a_reset_zero: assert property (disable iff (1'b0)
    !rst_n |=> cfg == '0 && !filter_restart)
    else $error("config not cleared by reset");
  a_reserved_zero: assert property (
    !cfg.routing_and_ready[0])
    else $error("reserved routing bit set");
  a_gain_code: assert property (
    plain_sel |-> analog.gain_mult == 8'h01 << cfg.input_and_gain[3:1])
    else $error("gain multiplier wrong");
  a_temp_ignore: assert property (
    cfg.rate_and_conv[ASC_TEMP_BIT] |->
    analog.input_select == 4'h0 && analog.gain_mult == ASC_GAIN_ONE)
    else $error("temperature mode not overriding");
  a_high_gain_amp: assert property (
    plain_sel && cfg.input_and_gain[3:1] > ASC_GAIN_MAX_BYPASS
    |-> analog.amp_en)
    else $error("amplifier off at high gain");
  a_bypass_clear: assert property (
    plain_sel && !cfg.input_and_gain[0] |-> analog.amp_en)
    else $error("amplifier off without bypass");
  a_bypass_set: assert property (
    plain_sel && cfg.input_and_gain[0] &&
    cfg.input_and_gain[3:1] <= ASC_GAIN_MAX_BYPASS |-> !analog.amp_en)
    else $error("bypass request ignored");
  a_ground_clamp: assert property (
    gnd_sel && !cfg.rate_and_conv[ASC_TEMP_BIT] |->
    !analog.amp_en && analog.gain_mult <= 8'h04)
    else $error("ground input not bypassed");
  // the bank and the restart flop load on the same core edge
  a_restart_follow: assert property (
    $changed(cfg) |-> filter_restart)
    else $error("no restart after config change");
  a_restart_pulse: assert property (
    filter_restart |=> !filter_restart)
    else $error("restart longer than one cycle");

  // main scenarios reached
  c_restart: cover property (filter_restart);
  c_temp: cover property (cfg.rate_and_conv[ASC_TEMP_BIT]);
  c_result: cover property (conv_done ##1 !drdy_n);
endmodule : asc_serial_cmd_asserts

bind asc_serial_cmd asc_serial_cmd_asserts u_asserts (.clk(clk),
  .rst_n(rst_n), .drdy_n(drdy_n), .conv_done(conv_done), .cfg(cfg),
  .analog(analog), .filter_restart(filter_restart));

`default_nettype wire

// *** tb/asc_host_model.sv ***
// serial host model: mode 1 frames, msb first
// assumes the device samples din on falling sclk edges
`timescale 1ns/100ps
`default_nettype none

module asc_host_model (
  output logic sclk, // serial clock, low between frames
  output logic cs_n, // chip select, active low
  output logic din, // serial data to the device
  input wire logic dout // serial data from the device
);
  // ------------------------------------------------------------
  // frame engine
  // ------------------------------------------------------------
  initial begin
    sclk = 1'b0;
    din = 1'b0;
    // a late rise clears the link logic once it is listening
    #1 cs_n = 1'b1;
  end

  // n bits at 32 ns per bit; whole bytes keep commands aligned
  task automatic frame(input int n, input logic [39:0] tx,
      output logic [39:0] rx);
    rx = '0;
    #5 cs_n = 1'b0;
    #16;
    for (int k = n - 1; k >= 0; k--) begin
      sclk = 1'b1;
      #2 din = tx[k];
      #14 rx = {rx[38:0], dout};
      sclk = 1'b0;
      #16;
    end
    // hold select so the core clock sees a write commit level
    #48;
    cs_n = 1'b1;
    // released line flips so stale data never passes for valid
    din = ~din;
  endtask : frame
endmodule : asc_host_model

`default_nettype wire

// *** tb/asc_serial_cmd_tb_top.sv ***
// self-checking bench for the adc serial command block
// assumes the host model drives the link and the checker is bound
`timescale 1ns/100ps
`default_nettype none

module asc_serial_cmd_tb_top
  import asc_pkg::*;
();
  logic clk, rst_n, conv_done;
  logic [15:0] conv_result;
  logic [39:0] rx;
  wire logic sclk, cs_n, din, dout, dout_oe_n, drdy_n, filter_restart;
  asc_cfg_s cfg;
  asc_analog_s analog;
  int n_fail, check_count;
  int n_restart = 0;

  asc_serial_cmd dut (.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
    .din(din), .dout(dout), .dout_oe_n(dout_oe_n), .drdy_n(drdy_n),
    .conv_result(conv_result), .conv_done(conv_done), .cfg(cfg),
    .analog(analog), .filter_restart(filter_restart));
  asc_host_model host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

  // ------------------------------------------------------------
  // clock, restart counter and tasks
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // one restart pulse expected per completed register write
  always @(posedge clk) begin
    if (filter_restart === 1'b1) begin
      n_restart <= n_restart + 1;
    end
  end

  task chk(input logic [39:0] got, input logic [39:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task gap(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : gap

  // frame, then room for a write commit to cross into clk
  task xfer(input int n, input logic [39:0] tx);
    host.frame(n, tx, rx);
    gap(8);
  endtask : xfer

  task wr(input logic [1:0] a, input logic [7:0] v);
    xfer(16, {24'h0, ASC_OP_REG_WRITE, a, 2'b00, v});
  endtask : wr

  task conv(input logic [15:0] v);
    conv_result = v;
    conv_done = 1'b1;
    gap(1);
    conv_done = 1'b0;
    gap(1);
    chk(drdy_n, 1'b0);
  endtask : conv

  task wrap_up;
    $display("fails=%0d checks=%0d", n_fail, check_count);
    if (n_fail == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    n_fail = 0;
    check_count = 0;
    rst_n = 1'b0;
    conv_done = 1'b0;
    conv_result = 16'h0000;
    gap(5);
    rst_n = 1'b1;
    gap(3);
    chk(cfg, 32'h0000_0000);
    chk({analog.gain_mult, analog.amp_en}, 9'h003);
    chk({dout_oe_n, drdy_n}, 2'b11);
    // four-byte write wrapping 3 -> 0, reserved bit offered as one
    xfer(40, 40'h4fa7_35e8_5c);
    chk(cfg, 32'ha65c_e835);
    chk(n_restart, 1);
    xfer(40, 40'h2300_0000_00);
    chk(rx[31:0], 32'h35e8_5ca6);
    xfer(24, 40'h2d_0000);
    chk(rx[15:0], 16'ha635);
    // plain readout with din held low
    conv(16'ha5c3);
    xfer(16, 40'h0);
    chk(rx[15:0], 16'ha5c3);
    chk(drdy_n, 1'b1);
    // read-result in the first byte aborts and restarts the word
    conv(16'h3c5a);
    xfer(24, 40'h10_0000);
    chk(rx[23:0], 24'h3c3c5a);
    // register read during the final byte keeps the word whole
    conv(16'h9617);
    xfer(24, 40'h00_2400);
    chk(rx[23:0], 24'h9617e8);
    // register write under a readout
    conv(16'h7e81);
    xfer(16, 40'h401b);
    chk(rx[15:0], 16'h7e81);
    chk(cfg.input_and_gain, 8'h1b);
    chk(n_restart, 2);
    // a write code inside register read data must not decode
    xfer(40, 40'h2041_ffff_00);
    chk(rx[31:24], 8'h1b);
    chk(cfg.input_and_gain, 8'h1b);
    chk(n_restart, 2);
    // a result landing mid-frame waits until the host lets go
    fork
      xfer(16, 40'h0);
      begin
        repeat (4) @(posedge clk);
        #2 conv_result = 16'h5aa5;
        conv_done = 1'b1;
        @(posedge clk);
        #2 conv_done = 1'b0;
        chk(dout_oe_n, 1'b0);
      end
    join
    chk(rx[15:0], 16'h7e81);
    chk(drdy_n, 1'b0);
    xfer(16, 40'h0);
    chk(rx[15:0], 16'h5aa5);
    for (int g = 0; g < 8; g++) begin
      wr(2'h0, {4'h0, 3'(g), 1'b1});
      chk(analog.gain_mult, 8'h01 << g);
      chk(analog.amp_en, g > 2);
    end
    wr(2'h0, 8'hd0);
    chk({analog.quarter_monitor, analog.amp_en}, 2'b10);
    wr(2'h0, 8'he0);
    chk(analog.mid_short, 1'b1);
    wr(2'h0, 8'hf0);
    chk(analog.sel_invalid, 1'b1);
    wr(2'h0, 8'h8e);
    chk({analog.gain_mult, analog.amp_en}, 9'h008);
    wr(2'h1, 8'h02);
    chk({analog.input_select, analog.gain_mult, analog.temp_mode},
      13'h003);
    chk(n_restart, 15);
    // second reset in mid-run
    rst_n = 1'b0;
    gap(5);
    chk(cfg, 32'h0000_0000);
    rst_n = 1'b1;
    gap(3);
    chk({analog.gain_mult, analog.amp_en, drdy_n}, 10'h007);
    wrap_up();
  end
endmodule : asc_serial_cmd_tb_top

`default_nettype wire
